// >>> apb_host_model.sv
// model: apb host issuing one register transfer at a time
`timescale 1ns/100ps
module apb_host_model (
  input  wire logic        clock,   // clock
  output logic             psel,    // select
  output logic             penable, // access phase
  output logic             pwrite,  // direction
  output logic      [11:0] paddr,   // byte address
  output logic      [31:0] pwdata,  // write data
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // ready
  input  wire logic        pslverr  // error
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // request held until pready is seen at an edge; no latency assumed
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// >>> daa_control_status_regs.sv
// module: apb control and status register bank for the daa system side
//
// Notes on behaviour
// - tx level on bits 6,1 drives call-progress output
// - rx level on bits 5,0 drives call-progress output
// - bit 4 powers down line side chip
// - bit 3 power down holds until internal reset
// - three-bit sample rate selects converter rate
// - revision register returns four-bit code, read-only
// - link error sticky until host writes zero
// - frame lock flag reads link lock state
// - off-hook: sense bits 4:1 with two exceptions
// - on-hook: loop current equals sense bits 4:1
// - off-hook bit drives hook and decode choice
`timescale 1ns/100ps
module daa_control_status_regs
  import daa_regs_pkg::*;
#(
  parameter logic [3:0] SYSTEM_SIDE_REVISION_CODE = REVISION_DEFAULT // arbitrary value
)
(
  input  wire logic        clock,                      // 100 MHz system clock
  input  wire logic        resetn,                     // async reset, active low
  input  wire logic        clock_enable,               // freezes all state when low
  input  wire logic        psel,                       // apb select
  input  wire logic        penable,                    // apb access phase
  input  wire logic        pwrite,                     // apb direction
  input  wire logic [11:0] paddr,                      // apb byte address
  input  wire logic [31:0] pwdata,                     // apb write data
  output logic      [31:0] prdata,                     // apb read data
  output logic             pready,                     // apb ready
  output logic             pslverr,                    // apb error on unmapped address
  input  wire logic        link_fail,                  // link failure event
  input  wire logic        link_frame_lock,            // link frame lock level
  input  wire logic [4:0]  line_voltage_current_sense, // line sense value
  input  wire logic        internal_reset,             // system-side internal reset pulse
  output daa_ctrl_t        ctrl,                       // control fields to the datapath
  output logic             irq                         // level interrupt
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] control_two_reg;
  logic [7:0] control_one_reg;
  logic [7:0] sample_rate_reg;
  logic       link_error_reg;
  logic       frame_lock_reg;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic [3:0] loop_current_field;
  logic       access_reg;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire logic [7:0] word_idx   = paddr[9:2];
  wire logic       aligned    = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00;
  wire logic       setup      = psel && !penable;
  wire logic       take       = psel && penable && pready;
  wire logic       do_write   = take && pwrite;
  wire logic       hit_ctl1   = aligned && word_idx == DAA_CONTROL_ONE_IDX;
  wire logic       hit_ctl2   = aligned && word_idx == DAA_CONTROL_TWO_IDX;
  wire logic       hit_rate   = aligned && word_idx == SAMPLE_RATE_CONTROL_IDX;
  wire logic       hit_rev    = aligned && word_idx == SYSTEM_SIDE_REVISION_IDX;
  wire logic       hit_stat   = aligned && word_idx == LINE_SIDE_STATUS_IDX;
  wire logic       hit_ist    = aligned && word_idx == IRQ_STATUS_IDX;
  wire logic       hit_imsk   = aligned && word_idx == IRQ_MASK_IDX;
  wire logic       hit_rsvd   = aligned && (word_idx == RESERVED_SEVEN_IDX ||
                                            word_idx == RESERVED_EIGHT_IDX ||
                                            word_idx == RESERVED_TEN_IDX);
  wire logic       mapped     = hit_ctl1 || hit_ctl2 || hit_rate || hit_rev || hit_stat ||
                                hit_ist || hit_imsk || hit_rsvd;

  // ------------------------------------------------------------
  // events
  // ------------------------------------------------------------
  wire logic       lock_lost  = frame_lock_reg && !link_frame_lock;
  wire logic       lock_got   = !frame_lock_reg && link_frame_lock;
  wire logic [2:0] irq_events = {lock_got, lock_lost, link_fail};

  // link error: a failure in the clearing cycle still wins
  wire logic link_clear = do_write && hit_stat && !pwdata[LINK_ERR_BIT];
  wire logic link_error_next = link_fail || (link_error_reg && !link_clear);

  wire logic [2:0] irq_status_next =
    irq_events | (irq_status_reg & ~((do_write && hit_ist) ? pwdata[2:0] : 3'h0));

  // power down sticks until internal reset; a host zero cannot wake it
  wire logic sys_pd_next = internal_reset ? 1'b0 :
    (control_two_reg[SYS_PD_BIT] || (do_write && hit_ctl2 && pwdata[SYS_PD_BIT]));

  wire logic [7:0] ctl2_written = pwdata[7:0] & CONTROL_TWO_MASK;
  wire logic [7:0] control_two_next =
    (do_write && hit_ctl2) ? {ctl2_written[7:4], sys_pd_next, ctl2_written[2:0]}
                           : {control_two_reg[7:4], sys_pd_next, control_two_reg[2:0]};

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  wire logic [7:0] status_byte = {link_error_reg, frame_lock_reg, 2'b00, loop_current_field};
  wire logic [7:0] read_byte =
    hit_ctl1 ? control_one_reg :
    hit_ctl2 ? control_two_reg :
    hit_rate ? sample_rate_reg :
    hit_rev  ? {4'h0, SYSTEM_SIDE_REVISION_CODE} :
    hit_stat ? status_byte :
    hit_ist  ? {5'h00, irq_status_reg} :
    hit_imsk ? {5'h00, irq_mask_reg} : 8'h00;

  // ------------------------------------------------------------
  // loop current decode
  // ------------------------------------------------------------
  loop_current_decode u_decode (
    .clock                      (clock),
    .resetn                     (resetn),
    .clock_enable               (clock_enable),
    .off_hook                   (control_one_reg[OFF_HOOK_BIT]),
    .line_voltage_current_sense (line_voltage_current_sense),
    .loop_current_field         (loop_current_field)
  );

  // ------------------------------------------------------------
  // bus handshake: no wait states, pready raised in the first access cycle, answer registered
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      access_reg <= 1'b0;
      pready     <= 1'b0;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
    end else if (clock_enable) begin
      access_reg <= setup;
      pready     <= setup;
      if (setup) begin
        prdata  <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, read_byte};
        pslverr <= !mapped;
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control_two_reg <= CONTROL_TWO_RESET;
      control_one_reg <= CONTROL_ONE_RESET;
      sample_rate_reg <= SAMPLE_RATE_RESET;
      link_error_reg  <= 1'b0;
      frame_lock_reg  <= 1'b0;
      irq_status_reg  <= IRQ_RESET;
      irq_mask_reg    <= IRQ_RESET;
      irq             <= 1'b0;
    end else if (clock_enable) begin
      control_two_reg <= control_two_next;
      if (do_write && hit_ctl1) begin
        control_one_reg <= {7'h00, pwdata[OFF_HOOK_BIT]};
      end
      if (do_write && hit_rate) begin
        sample_rate_reg <= {5'h00, pwdata[2:0]};
      end
      if (do_write && hit_imsk) begin
        irq_mask_reg <= pwdata[2:0];
      end
      link_error_reg <= link_error_next;
      frame_lock_reg <= link_frame_lock;
      irq_status_reg <= irq_status_next;
      irq            <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ------------------------------------------------------------
  // control outputs, registered
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= '{call_progress_out_tx_level: TX_MUTE, call_progress_out_rx_level: RX_MUTE,
                line_side_powerdown: 1'b1, system_side_powerdown: 1'b0,
                sample_rate_select: RATE_7200, off_hook_ctl: 1'b0};
    end else if (clock_enable) begin
      ctrl.call_progress_out_tx_level <= tx_level_t'({control_two_next[TX_LEVEL_HI_BIT],
                                         control_two_next[TX_LEVEL_LO_BIT]});
      ctrl.call_progress_out_rx_level <= rx_level_t'({control_two_next[RX_LEVEL_HI_BIT],
                                         control_two_next[RX_LEVEL_LO_BIT]});
      ctrl.line_side_powerdown   <= control_two_next[LINE_PD_BIT];
      ctrl.system_side_powerdown <= control_two_next[SYS_PD_BIT];
      ctrl.sample_rate_select    <= (do_write && hit_rate) ? sample_rate_t'(pwdata[2:0])
                                    : sample_rate_t'(sample_rate_reg[2:0]);
      ctrl.off_hook_ctl          <= (do_write && hit_ctl1) ? pwdata[OFF_HOOK_BIT]
                                    : control_one_reg[OFF_HOOK_BIT];
    end
  end

endmodule

// >>> daa_regs_pkg.sv
// package: offsets, field positions, reset values and carrier types for the daa register bank
package daa_regs_pkg;

  // ------------------------------------------------------------
  // register word indices (each register takes one aligned word)
  // ------------------------------------------------------------
  localparam logic [7:0] DAA_CONTROL_ONE_IDX      = 8'h05;
  localparam logic [7:0] DAA_CONTROL_TWO_IDX      = 8'h06;
  localparam logic [7:0] RESERVED_SEVEN_IDX       = 8'h07;
  localparam logic [7:0] RESERVED_EIGHT_IDX       = 8'h08;
  localparam logic [7:0] SAMPLE_RATE_CONTROL_IDX  = 8'h09;
  localparam logic [7:0] RESERVED_TEN_IDX         = 8'h0A;
  localparam logic [7:0] SYSTEM_SIDE_REVISION_IDX = 8'h0B;
  localparam logic [7:0] LINE_SIDE_STATUS_IDX     = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_IDX           = 8'h10;
  localparam logic [7:0] IRQ_MASK_IDX             = 8'h11;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int TX_LEVEL_HI_BIT   = 6;
  localparam int TX_LEVEL_LO_BIT   = 1;
  localparam int RX_LEVEL_HI_BIT   = 5;
  localparam int RX_LEVEL_LO_BIT   = 0;
  localparam int LINE_PD_BIT       = 4;
  localparam int SYS_PD_BIT        = 3;
  localparam int OFF_HOOK_BIT      = 0;
  localparam int LINK_ERR_BIT      = 7;
  localparam int FRAME_LOCK_BIT    = 6;
  localparam int IRQ_LINK_ERR_BIT  = 0;
  localparam int IRQ_LOCK_LOST_BIT = 1;
  localparam int IRQ_LOCK_GOT_BIT  = 2;

  // ------------------------------------------------------------
  // reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] CONTROL_TWO_RESET  = 8'h70;
  localparam logic [7:0] CONTROL_TWO_MASK   = 8'h7B;
  localparam logic [7:0] CONTROL_ONE_RESET  = 8'h00;
  localparam logic [7:0] SAMPLE_RATE_RESET  = 8'h00;
  localparam logic [2:0] IRQ_RESET          = 3'h0;
  localparam logic [3:0] REVISION_DEFAULT   = 4'h1; // arbitrary value
  localparam logic [3:0] APB_ADDR_LSB       = 4'h2;

  // ------------------------------------------------------------
  // modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_ATT_26DB, TX_ATT_20DB, TX_MUTE, TX_ATT_32DB
  } tx_level_t;

  typedef enum logic [1:0] {
    RX_ATT_6DB, RX_ATT_0DB, RX_MUTE, RX_ATT_12DB
  } rx_level_t;

  typedef enum logic [2:0] {
    RATE_7200, RATE_8000, RATE_8229, RATE_8400,
    RATE_9000, RATE_9600, RATE_10286, RATE_RESERVED
  } sample_rate_t;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    tx_level_t    call_progress_out_tx_level;
    rx_level_t    call_progress_out_rx_level;
    logic         line_side_powerdown;
    logic         system_side_powerdown;
    sample_rate_t sample_rate_select;
    logic         off_hook_ctl;
  } daa_ctrl_t;

  typedef struct packed {
    logic       link_error;
    logic       frame_lock;
    logic [4:0] line_voltage_current_sense;
  } line_stat_t;

endpackage

// >>> daa_regs_sva.sv
// checker: port assertions for the daa register bank
`timescale 1ns/100ps
module daa_regs_sva
  import daa_regs_pkg::*;
#(
  parameter logic [3:0] SYSTEM_SIDE_REVISION_CODE = REVISION_DEFAULT // arbitrary value
)
(
  input wire logic        clock,          // clock
  input wire logic        resetn,         // reset, active low
  input wire logic        psel,           // select
  input wire logic        penable,        // access phase
  input wire logic        pwrite,         // direction
  input wire logic [11:0] paddr,          // byte address
  input wire logic [31:0] pwdata,         // write data
  input wire logic [31:0] prdata,         // read data
  input wire logic        pready,         // ready
  input wire logic        pslverr,        // error
  input wire logic        internal_reset, // powerdown clear
  input wire daa_ctrl_t   ctrl            // control fields
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic done_w;
  logic done_r;
  assign done_w = psel && penable && pready && pwrite;
  assign done_r = psel && penable && pready && !pwrite;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_tx;
    done_w && paddr == 12'h018 |=> ctrl.call_progress_out_tx_level == {$past(pwdata[6]), $past(pwdata[1])};
  endproperty
  a_tx: assert property (p_tx) else $error("tx level not taken");
  property p_rx;
    done_w && paddr == 12'h018 |=> ctrl.call_progress_out_rx_level == {$past(pwdata[5]), $past(pwdata[0])};
  endproperty
  a_rx: assert property (p_rx) else $error("rx level not taken");
  property p_lpd;
    done_w && paddr == 12'h018 |=> ctrl.line_side_powerdown == $past(pwdata[4]);
  endproperty
  a_lpd: assert property (p_lpd) else $error("line powerdown not taken");
  // a written zero must not wake the system side
  property p_spd;
    ctrl.system_side_powerdown && !internal_reset |=> ctrl.system_side_powerdown;
  endproperty
  a_spd: assert property (p_spd) else $error("powerdown left without reset");
  property p_rate;
    done_w && paddr == 12'h024 |=> ctrl.sample_rate_select == $past(pwdata[2:0]);
  endproperty
  a_rate: assert property (p_rate) else $error("rate not taken");
  property p_rev;
    done_r && paddr == 12'h02C |-> prdata == {28'h0000000, SYSTEM_SIDE_REVISION_CODE};
  endproperty
  a_rev: assert property (p_rev) else $error("revision read wrong");
  property p_hook;
    done_w && paddr == 12'h014 |=> ctrl.off_hook_ctl == $past(pwdata[0]);
  endproperty
  a_hook: assert property (p_hook) else $error("hook bit not taken");
  property p_rsvd;
    done_r && (paddr == 12'h01C || paddr == 12'h020 || paddr == 12'h028)
      |-> prdata == 32'h00000000 && !pslverr;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  c_ctl2: cover property (done_w && paddr == 12'h018);
  c_stat: cover property (done_r && paddr == 12'h030);
  c_err: cover property (pready && pslverr);
endmodule
bind daa_control_status_regs daa_regs_sva #(
  .SYSTEM_SIDE_REVISION_CODE(SYSTEM_SIDE_REVISION_CODE)
) daa_regs_sva_i (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .internal_reset, .ctrl);

// >>> loop_current_decode.sv
// module: loop current field decode from the line sense value
`timescale 1ns/100ps
module loop_current_decode
  import daa_regs_pkg::*;
(
  input  wire logic       clock,                      // system clock
  input  wire logic       resetn,                     // async reset, active low
  input  wire logic       clock_enable,               // freezes state when low
  input  wire logic       off_hook,                   // current hook state
  input  wire logic [4:0] line_voltage_current_sense, // raw sense value
  output logic      [3:0] loop_current_field          // registered decode
);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic [3:0] plain_field = line_voltage_current_sense[4:1];
  wire logic       is_top      = line_voltage_current_sense == 5'h1E;
  wire logic       is_one      = line_voltage_current_sense == 5'h01;
  wire logic [3:0] hook_field  = is_top ? 4'hE : (is_one ? 4'h1 : plain_field);
  wire logic [3:0] field_next  = off_hook ? hook_field : plain_field;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      loop_current_field <= 4'h0;
    end else if (clock_enable) begin
      loop_current_field <= field_next;
    end
  end

endmodule

// >>> tb_daa_control_status_regs.sv
// testbench: register bank scenarios through the apb host model
`timescale 1ns/100ps
module tb_daa_control_status_regs import daa_regs_pkg::*;;
  logic        clock, resetn, clock_enable, link_fail, link_frame_lock, internal_reset;
  logic        psel, penable, pwrite, pready, pslverr, irq;
  logic [4:0]  sense;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  v;
  daa_ctrl_t   ctrl;
  int          error_cnt = 0;
  int          samples_checked = 0;
  apb_host_model host_i (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  daa_control_status_regs daa_control_status_regs_i (.clock(clock), .resetn(resetn),
    .clock_enable(clock_enable), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_fail(link_fail), .link_frame_lock(link_frame_lock),
    .line_voltage_current_sense(sense), .internal_reset(internal_reset), .ctrl(ctrl),
    .irq(irq));
  always #5 clock = ~clock;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    host_i.xfer(1'b1, idx, d, r, e);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic        e;
    host_i.xfer(1'b0, idx, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, eexp});
  endtask
  task automatic chk_ctl2(input logic [7:0] c);
    chk(32'(ctrl.call_progress_out_tx_level), {30'h0, c[6], c[1]});
    chk(32'(ctrl.call_progress_out_rx_level), {30'h0, c[5], c[0]});
    chk(32'(ctrl.line_side_powerdown), {31'h0, c[4]});
    chk(32'(ctrl.system_side_powerdown), {31'h0, c[3]});
  endtask
  function automatic logic [3:0] lc(input logic oh, input logic [4:0] s);
    if (oh && s == 5'h1E) return 4'hE;
    if (oh && s == 5'h01) return 4'h1;
    return s[4:1];
  endfunction
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {clock, resetn, link_fail, link_frame_lock, internal_reset, sense} = '0;
    clock_enable = 1'b1;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    rdc(DAA_CONTROL_TWO_IDX, {24'h0, CONTROL_TWO_RESET}, 1'b0);
    chk_ctl2(CONTROL_TWO_RESET);
    rdc(SAMPLE_RATE_CONTROL_IDX, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      v = {1'b1, i[1], ~i[1], i[0], 1'b0, 1'b1, i[0], ~i[0]};
      wr(DAA_CONTROL_TWO_IDX, {24'h0, v});
      rdc(DAA_CONTROL_TWO_IDX, {24'h0, v & 8'h7B}, 1'b0);
      chk_ctl2(v);
    end
    wr(DAA_CONTROL_TWO_IDX, 32'h08);
    wr(DAA_CONTROL_TWO_IDX, 32'h00);
    rdc(DAA_CONTROL_TWO_IDX, 32'h08, 1'b0);
    internal_reset <= 1'b1;
    @(posedge clock);
    internal_reset <= 1'b0;
    rdc(DAA_CONTROL_TWO_IDX, 32'h00, 1'b0);
    $display("test control two done");
    for (int r = 0; r < 8; r++) begin
      wr(SAMPLE_RATE_CONTROL_IDX, 32'hF8 | r);
      rdc(SAMPLE_RATE_CONTROL_IDX, r, 1'b0);
      chk(32'(ctrl.sample_rate_select), r);
    end
    wr(SYSTEM_SIDE_REVISION_IDX, 32'hFF);
    rdc(SYSTEM_SIDE_REVISION_IDX, {28'h0, REVISION_DEFAULT}, 1'b0);
    foreach (v[k]) if (k < 3) begin
      wr(k == 0 ? RESERVED_SEVEN_IDX : k == 1 ? RESERVED_EIGHT_IDX : RESERVED_TEN_IDX, 32'hFF);
      rdc(k == 0 ? RESERVED_SEVEN_IDX : k == 1 ? RESERVED_EIGHT_IDX : RESERVED_TEN_IDX,
          32'h0, 1'b0);
    end
    rdc(8'h3F, 32'h0, 1'b1);
    $display("test rate revision reserved done");
    link_fail <= 1'b1;
    @(posedge clock);
    link_fail <= 1'b0;
    rdc(LINE_SIDE_STATUS_IDX, 32'h80, 1'b0);
    chk({31'h0, irq}, 32'h0);
    wr(IRQ_MASK_IDX, 32'h1);
    wr(LINE_SIDE_STATUS_IDX, 32'h80);
    rdc(LINE_SIDE_STATUS_IDX, 32'h80, 1'b0);
    chk({31'h0, irq}, 32'h1);
    wr(LINE_SIDE_STATUS_IDX, 32'h00);
    wr(IRQ_STATUS_IDX, 32'h1);
    rdc(LINE_SIDE_STATUS_IDX, 32'h00, 1'b0);
    chk({31'h0, irq}, 32'h0);
    link_frame_lock <= 1'b1;
    rdc(IRQ_STATUS_IDX, 32'h4, 1'b0);
    chk({31'h0, irq}, 32'h0);
    $display("test link status done");
    for (int oh = 0; oh < 2; oh++) begin
      wr(DAA_CONTROL_ONE_IDX, oh);
      foreach (v[k]) if (k < 5) begin
        sense <= k == 0 ? 5'h1E : k == 1 ? 5'h01 : k == 2 ? 5'h15 : k == 3 ? 5'h1F : 5'h00;
        repeat (3) @(posedge clock);
        rdc(LINE_SIDE_STATUS_IDX, {24'h0, 4'h4, lc(oh[0], sense)}, 1'b0);
      end
      chk(32'(ctrl.off_hook_ctl), oh);
    end
    $display("test loop current done");
    link_frame_lock <= 1'b0;
    repeat (2) @(posedge clock);
    rdc(IRQ_STATUS_IDX, 32'h6, 1'b0);
    clock_enable <= 1'b0;
    link_fail    <= 1'b1;
    @(posedge clock);
    link_fail    <= 1'b0;
    clock_enable <= 1'b1;
    rdc(LINE_SIDE_STATUS_IDX, {28'h0, lc(1'b1, sense)}, 1'b0);
    $display("test lock lost and freeze done");
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end
endmodule
